// [lrm_pkg.sv]
// Constants, register map and mode helpers for the LCD RAM multiplex core
package lrm_pkg;
	// ==========================================================
	// Geometry
	localparam int NUM_SEG   = 40;
	localparam int NUM_BP    = 4;
	localparam int PTR_W     = 6;
	localparam int SUB_W     = 3;
	localparam logic [5:0] LAST_ADDR = 6'h27;

	// ==========================================================
	// Timing
	localparam int FRAME_DIV       = 24;
	localparam int BLINK_DIV_FAST  = 768;
	localparam int BLINK_DIV_MID   = 1536;
	localparam int BLINK_DIV_SLOW  = 3072;
	localparam int PCLK_HZ         = 20000000;
	localparam int OSC_HZ          = 1536;
	localparam int OSC_HALF_CYC    = PCLK_HZ / (2 * OSC_HZ);

	// ==========================================================
	// Register offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_PTR  = 8'h04;
	localparam logic [7:0] OFS_SUB  = 8'h08;
	localparam logic [7:0] OFS_DATA = 8'h0c;
	localparam logic [7:0] OFS_STAT = 8'h10;

	// ==========================================================
	// Control fields and reset value
	localparam int CTRL_MODE  = 0;
	localparam int CTRL_SHOW  = 2;
	localparam int CTRL_BLINK = 3;
	localparam int CTRL_ALT   = 5;
	localparam int CTRL_INB   = 6;
	localparam int CTRL_OUTB  = 7;
	localparam logic [7:0] CTRL_RST = 8'h00;

	// ==========================================================
	// Drive modes and blink rates
	localparam logic [1:0] MODE_1TO4   = 2'h0;
	localparam logic [1:0] MODE_STATIC = 2'h1;
	localparam logic [1:0] MODE_1TO2   = 2'h2;
	localparam logic [1:0] MODE_1TO3   = 2'h3;
	localparam logic [1:0] BLINK_OFF   = 2'h0;
	localparam logic [1:0] BLINK_FAST  = 2'h1;
	localparam logic [1:0] BLINK_MID   = 2'h2;

	// ==========================================================
	// Helpers
	function automatic logic [1:0] lrm_last_phase(input logic [1:0] m);
		case (m)
			MODE_STATIC: lrm_last_phase = 2'h0;
			MODE_1TO2:   lrm_last_phase = 2'h1;
			MODE_1TO3:   lrm_last_phase = 2'h2;
			default:     lrm_last_phase = 2'h3;
		endcase
	endfunction : lrm_last_phase

	function automatic logic [5:0] lrm_step(input logic [1:0] m);
		case (m)
			MODE_STATIC: lrm_step = 6'h08;
			MODE_1TO2:   lrm_step = 6'h04;
			MODE_1TO3:   lrm_step = 6'h03;
			default:     lrm_step = 6'h02;
		endcase
	endfunction : lrm_step

	function automatic logic lrm_banked(input logic [1:0] m);
		lrm_banked = (m == MODE_STATIC) || (m == MODE_1TO2);
	endfunction : lrm_banked

	typedef enum logic {ST_IDLE, ST_STORE} lrm_store_t;
endpackage : lrm_pkg

// [lrm_core.sv]
// LCD display RAM, multiplex timing, blinking and APB register slave
// Notes on behaviour
// - Internal oscillator when select pin low, else clock pin is external input.
// - Frame tick is the active clock divided by 24.
// - Latch holds one row of RAM while the slot is shown.
// - Forty segment outputs follow latched bit and backplane phase.
// - Backplanes mirror by mode: 1:3 bp3=bp1, 1:2 pairs, static all.
// - RAM is 40 words of 4 bits; 1 means segment on.
// - Each data bit is stored as soon as it is shifted in.
// - Byte scatters into 1, 2, 3 or 4 bits per address by mode.
// - In 1:3 mode third address keeps bit 2 unchanged.
// - Pointer advances 8, 4, 3 or 2 per byte; load sets it.
// - Store only when subaddress counter matches pins; pointer always advances.
// - Subaddress counter loads by command and increments on pointer overflow.
// - Output bank selector steps rows per frame by mode.
// - Cascade align restarts row sequence at last row of the mode.
// - Output bank may show bits 2-3 in static and 1:2 modes.
// - Input bank may store into bits 2-3, independent of output bank.
// - Whole display blinks at selected rate, or blinking off.
// - Alternate-bank blinking toggles output bank at blink rate in static and 1:2 modes only.
// - Blink periods are clock divided by 768, 1536 or 3072.
// - Reset clears pointer, subaddress, banks, display and blinking.
// - Pointer load carries six bits.
// - Subaddress load carries three bits.
//
// The APB interface to the registers and the placing of the registers were decided locally.
module lrm_core
	import lrm_pkg::*;
#(
	parameter int OSC_HALF = OSC_HALF_CYC
)(
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic                 osc_select_pin,
	input  wire logic                 clk_pin_in,
	output logic                      clk_pin_out,
	output logic                      clk_pin_oe,
	input  wire logic [SUB_W-1:0]     hardware_subaddress,
	input  wire logic                 cascade_align,
	output logic      [NUM_SEG-1:0]   segment_outputs,
	output logic      [NUM_BP-1:0]    backplane_outputs
);
	// ==========================================================
	// Pin synchronisers
	logic [1:0]       osc_sync;
	logic [1:0]       align_sync;
	logic [2:0]       clkin_sync;
	logic [SUB_W-1:0] hw_sub_meta;
	logic [SUB_W-1:0] hw_sub;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_sync    <= 2'h0;
			align_sync  <= 2'h0;
			clkin_sync  <= 3'h0;
			hw_sub_meta <= 3'h0;
			hw_sub      <= 3'h0;
		end else begin
			osc_sync    <= {osc_sync[0], osc_select_pin};
			align_sync  <= {align_sync[0], cascade_align};
			clkin_sync  <= {clkin_sync[1:0], clk_pin_in};
			hw_sub_meta <= hardware_subaddress;
			hw_sub      <= hw_sub_meta;
		end
	end

	wire osc_internal = !osc_sync[1];
	wire align_s      = align_sync[1];
	wire ext_rise     = clkin_sync[1] && !clkin_sync[2];

	// ==========================================================
	// Oscillator and active clock tick
	logic [15:0] osc_cnt;
	logic        osc_level;
	wire         osc_wrap = osc_cnt == 16'(OSC_HALF - 1);
	wire         int_tick = osc_wrap && !osc_level;
	wire         tick     = osc_internal ? int_tick : ext_rise;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_cnt     <= 16'h0000;
			osc_level   <= 1'b0;
			clk_pin_out <= 1'b0;
			clk_pin_oe  <= 1'b0;
		end else begin
			osc_cnt     <= osc_wrap ? 16'h0000 : osc_cnt + 16'h0001;
			if (osc_wrap)
				osc_level <= !osc_level;
			clk_pin_out <= osc_level && osc_internal;
			clk_pin_oe  <= osc_internal;
		end
	end

	// ==========================================================
	// Control register and APB decode
	logic [7:0] ctrl;
	wire  [1:0] mode      = ctrl[CTRL_MODE +: 2];
	wire        show      = ctrl[CTRL_SHOW];
	wire  [1:0] blink_sel = ctrl[CTRL_BLINK +: 2];
	wire        alt_blink = ctrl[CTRL_ALT];
	wire        in_bank   = ctrl[CTRL_INB];
	wire        out_bank  = ctrl[CTRL_OUTB];

	wire access   = psel && penable;
	wire take     = access && pready;
	wire hit_ctrl = paddr == OFS_CTRL;
	wire hit_ptr  = paddr == OFS_PTR;
	wire hit_sub  = paddr == OFS_SUB;
	wire hit_data = paddr == OFS_DATA;
	wire hit_stat = paddr == OFS_STAT;
	wire mapped   = hit_ctrl || hit_ptr || hit_sub || hit_data || hit_stat;
	wire data_wr  = hit_data && pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctrl <= CTRL_RST;
		else if (take && pwrite && hit_ctrl)
			ctrl <= pwdata[7:0];
	end

	// ==========================================================
	// Store engine: one data bit per cycle
	lrm_store_t        st;
	logic [PTR_W-1:0]  ptr;
	logic [SUB_W-1:0]  sub;
	logic [7:0]        shreg;
	logic [2:0]        bit_cnt;
	logic [1:0]        k;
	logic              dw_done;
	logic [PTR_W-1:0]  ptr_start;

	wire busy      = st == ST_STORE;
	wire start     = access && data_wr && !busy && !dw_done && !pready;
	wire step      = busy;
	wire last_bit  = bit_cnt == 3'h0;
	wire adv       = (k == lrm_last_phase(mode)) || last_bit;
	wire overflow  = ptr >= LAST_ADDR;
	wire store_en  = step && (sub == hw_sub);
	wire [1:0] bank_base = (in_bank && lrm_banked(mode)) ? 2'h2 : 2'h0;
	wire [1:0] dest      = k + bank_base;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st        <= ST_IDLE;
			ptr       <= 6'h00;
			sub       <= 3'h0;
			shreg     <= 8'h00;
			bit_cnt   <= 3'h0;
			k         <= 2'h0;
			dw_done   <= 1'b0;
			ptr_start <= 6'h00;
		end else begin
			case (st)
				ST_IDLE: begin
					if (start) begin
						st        <= ST_STORE;
						shreg     <= pwdata[7:0];
						bit_cnt   <= 3'h7;
						k         <= 2'h0;
						ptr_start <= ptr;
					end else if (take && pwrite && hit_ptr) begin
						ptr <= pwdata[PTR_W-1:0];
						k   <= 2'h0;
					end else if (take && pwrite && hit_sub) begin
						sub <= pwdata[SUB_W-1:0];
					end
					if (take)
						dw_done <= 1'b0;
				end
				ST_STORE: begin
					shreg   <= {shreg[6:0], 1'b0};
					bit_cnt <= bit_cnt - 3'h1;
					if (adv) begin
						k <= 2'h0;
						if (overflow) begin
							ptr <= 6'h00;
							sub <= sub + 3'h1;
						end else begin
							ptr <= ptr + 6'h01;
						end
					end else begin
						k <= k + 2'h1;
					end
					if (last_bit) begin
						st      <= ST_IDLE;
						dw_done <= 1'b1;
					end
				end
				default: st <= ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Display RAM
	logic [NUM_BP-1:0] ram [0:NUM_SEG-1];

	always_ff @(posedge pclk) begin
		if (store_en)
			ram[ptr][dest] <= shreg[7];
	end

	// ==========================================================
	// Frame timing and output bank selector
	logic [4:0] frame_cnt;
	logic [1:0] phase;
	logic [11:0] blink_cnt;
	logic        blink_state;

	wire        frame_tick = tick && (frame_cnt == 5'(FRAME_DIV - 1));
	wire  [1:0] last_ph    = lrm_last_phase(mode);
	wire  [1:0] next_phase = (phase >= last_ph) ? 2'h0 : phase + 2'h1;
	wire        blink_on   = blink_sel != BLINK_OFF;
	wire        bank_flip  = alt_blink && blink_on && blink_state;
	wire        alt_view   = lrm_banked(mode) && (out_bank ^ bank_flip);
	wire  [1:0] row_sel    = next_phase + (alt_view ? 2'h2 : 2'h0);
	wire        blank      = blink_on && !alt_blink && blink_state;

	wire [11:0] blink_half =
		(blink_sel == BLINK_FAST) ? 12'(BLINK_DIV_FAST / 2) :
		(blink_sel == BLINK_MID)  ? 12'(BLINK_DIV_MID / 2)  :
		12'(BLINK_DIV_SLOW / 2);
	wire blink_wrap = tick && (blink_cnt == blink_half - 12'h001);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_cnt <= 5'h00;
			phase     <= 2'h0;
		end else if (align_s) begin
			frame_cnt <= 5'h00;
			phase     <= last_ph;
		end else if (frame_tick) begin
			frame_cnt <= 5'h00;
			phase     <= next_phase;
		end else if (tick) begin
			frame_cnt <= frame_cnt + 5'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blink_cnt   <= 12'h000;
			blink_state <= 1'b0;
		end else if (!blink_on) begin
			blink_cnt   <= 12'h000;
			blink_state <= 1'b0;
		end else if (blink_wrap) begin
			blink_cnt   <= 12'h000;
			blink_state <= !blink_state;
		end else if (tick) begin
			blink_cnt <= blink_cnt + 12'h001;
		end
	end

	// ==========================================================
	// Display latch and drivers
	logic [NUM_SEG-1:0] latch;
	logic [NUM_BP-1:0]  bp_next;

	always_comb begin
		bp_next[0] = phase == 2'h0;
		bp_next[1] = (mode == MODE_STATIC) ? phase == 2'h0 : phase == 2'h1;
		bp_next[2] = (mode == MODE_1TO4 || mode == MODE_1TO3) ?
			phase == 2'h2 : phase == 2'h0;
		bp_next[3] = (mode == MODE_1TO4) ? phase == 2'h3 :
			(mode == MODE_STATIC) ? phase == 2'h0 : phase == 2'h1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latch <= '0;
		end else if (frame_tick) begin
			for (int i = 0; i < NUM_SEG; i++)
				latch[i] <= ram[i][row_sel];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			segment_outputs   <= '0;
			backplane_outputs <= '0;
		end else begin
			segment_outputs   <= (show && !blank) ? latch : '0;
			backplane_outputs <= show ? bp_next : '0;
		end
	end

	// ==========================================================
	// APB answer
	wire next_pready = access && !pready && (!data_wr || dw_done);
	wire [31:0] rd_mux =
		hit_ctrl ? {24'h0, ctrl} :
		hit_ptr  ? {26'h0, ptr} :
		hit_sub  ? {29'h0, sub} :
		hit_stat ? {24'h0, osc_internal, hw_sub, busy, blink_state, phase} :
		32'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= next_pready;
			pslverr <= next_pready && !mapped;
			if (next_pready)
				prdata <= pwrite ? 32'h0 : rd_mux;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic [4:0] tk_since;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tk_since <= 5'h00;
		else if (frame_tick || align_s)
			tk_since <= 5'h00;
		else if (tick && tk_since != 5'h1f)
			tk_since <= tk_since + 5'h01;
	end

	a_frame_period: assert property (
		frame_tick |-> tk_since == 5'(FRAME_DIV - 1))
		else $error("frame tick at wrong count");
	a_row_step: assert property (
		frame_tick && !align_s |=> phase == ($past(phase) >= $past(last_ph) ? 2'h0 : $past(phase) + 2'h1))
		else $error("row sequence wrong");
	a_align_start: assert property (
		align_s ##1 align_s |-> phase == lrm_last_phase($past(mode)))
		else $error("align did not restart row");
	a_pair_mirror: assert property (
		mode == MODE_1TO2 && $past(mode) == MODE_1TO2 |->
			backplane_outputs[0] == backplane_outputs[2] &&
			backplane_outputs[1] == backplane_outputs[3])
		else $error("1:2 backplanes differ");
	a_static_mirror: assert property (
		mode == MODE_STATIC && $past(mode) == MODE_STATIC |->
			backplane_outputs == {4{backplane_outputs[0]}})
		else $error("static backplanes differ");
	a_byte_step: assert property (
		$fell(busy) && ptr_start <= LAST_ADDR |->
			ptr == ((ptr_start + lrm_step(mode) > LAST_ADDR) ?
			ptr_start + lrm_step(mode) - 6'h28 : ptr_start + lrm_step(mode)))
		else $error("pointer step wrong");
	a_sub_carry: assert property (
		step && adv && overflow |=> sub == $past(sub) + 3'h1 && ptr == 6'h00)
		else $error("overflow did not carry");
	a_store_bit: assert property (
		store_en |=> ram[$past(ptr)][$past(dest)] == $past(shreg[7]))
		else $error("bit not stored");
	a_dark_off: assert property (
		!show |=> segment_outputs == '0 && backplane_outputs == '0)
		else $error("outputs live while disabled");
	a_ready_pulse: assert property (
		pready |=> !pready)
		else $error("pready held");
endmodule : lrm_core

// [lrm_host.sv]
// APB host model that issues register transfers to the core
module lrm_host (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	timeunit 1ns;
	timeprecision 1ns;

	// ==========================================================
	// Idle bus
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
	end

	// ==========================================================
	// One transfer: setup, access until pready, then release
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : lrm_host

// [test_lrm_core.sv]
// Self-checking bench for the LCD RAM multiplex core
module test_lrm_core;
	import lrm_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        osc_select_pin, clk_pin_out, clk_pin_oe, cascade_align;
	logic [2:0]  hardware_subaddress;
	logic [2:0]  ext_cnt = 3'h0;
	logic [39:0] segment_outputs;
	logic [3:0]  backplane_outputs;
	wire         clk_pin = clk_pin_oe ? clk_pin_out : ext_cnt[1];
	int          n_mismatch = 0;
	int          checks = 0;
	logic [1:0]  md [4] = '{MODE_1TO4, MODE_STATIC, MODE_1TO2, MODE_1TO3};
	logic [7:0]  stp [4] = '{8'h02, 8'h08, 8'h04, 8'h03};
	logic [1:0]  lr [4] = '{2'h3, 2'h0, 2'h1, 2'h2};
	logic [3:0]  rm [4] = '{4'hf, 4'h1, 4'h3, 4'h7};

	// ==========================================================
	// Clock, external clock pin and instances
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	always @(posedge pclk) ext_cnt <= ext_cnt + 3'h1;

	lrm_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	lrm_core #(.OSC_HALF(2)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.osc_select_pin(osc_select_pin), .clk_pin_in(clk_pin), .clk_pin_out(clk_pin_out),
		.clk_pin_oe(clk_pin_oe), .hardware_subaddress(hardware_subaddress),
		.cascade_align(cascade_align), .segment_outputs(segment_outputs),
		.backplane_outputs(backplane_outputs));

	// ==========================================================
	// Tasks
	task automatic end_of_test();
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		host.xfer(1'b1, a, d, r, e);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		logic e;
		host.xfer(1'b0, a, 32'h00000000, r, e);
	endtask : rd

	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] exp);
		logic [31:0] r;
		rd(a, r);
		chk(nm, 40'(exp), 40'(r));
	endtask : rd_chk

	task automatic wait_seg(input logic [7:0] v, output int c);
		c = 0;
		do begin
			@(posedge pclk);
			c++;
		end while (segment_outputs[7:0] !== v && c < 7000);
	endtask : wait_seg

	task automatic row_mask(output logic [3:0] m);
		logic [31:0] r;
		m = 4'h0;
		repeat (8) begin
			repeat (97) @(posedge pclk);
			rd(OFS_STAT, r);
			m[r[1:0]] = 1'b1;
		end
	endtask : row_mask

	function automatic logic [3:0] mirror(input logic [1:0] m, input logic [3:0] b);
		case (m)
			MODE_STATIC: mirror = {4{b[0]}};
			MODE_1TO2:   mirror = {b[1:0], b[1:0]};
			MODE_1TO3:   mirror = {b[1], b[2:0]};
			default:     mirror = b;
		endcase
	endfunction : mirror

	// ==========================================================
	// Watchdog
	initial begin
		repeat (80000) @(posedge pclk);
		n_mismatch++;
		end_of_test();
	end

	// ==========================================================
	// Tests
	initial begin
		logic [31:0] r;
		logic        e;
		logic [3:0]  m;
		int          c;
		int          d;
		presetn = 1'b0;
		osc_select_pin = 1'b0;
		cascade_align = 1'b0;
		hardware_subaddress = 3'h0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk("ctrl", OFS_CTRL, CTRL_RST);
		rd_chk("ptr", OFS_PTR, 8'h00);
		rd_chk("sub", OFS_SUB, 8'h00);
		chk("outputs", 40'h0, {segment_outputs[35:0], backplane_outputs});
		host.xfer(1'b0, 8'h14, 32'h0, r, e);
		chk("slverr", 40'h1, 40'(e));
		wr(OFS_PTR, 32'hff);
		rd_chk("ptr", OFS_PTR, 8'h3f);
		wr(OFS_SUB, 32'hff);
		rd_chk("sub", OFS_SUB, 8'h07);
		wr(OFS_SUB, 32'h0);
		wr(OFS_CTRL, 32'h05);
		wr(OFS_PTR, 32'h0);
		wr(OFS_DATA, 32'hc1);
		repeat (200) @(posedge pclk);
		chk("seg", 40'h83, 40'(segment_outputs[7:0]));
		chk("bp", 40'hf, 40'(backplane_outputs));
		wr(OFS_SUB, 32'h1);
		wr(OFS_PTR, 32'h0);
		wr(OFS_DATA, 32'hff);
		rd_chk("ptr", OFS_PTR, 8'h08);
		repeat (200) @(posedge pclk);
		chk("seg", 40'h83, 40'(segment_outputs[7:0]));
		wr(OFS_SUB, 32'h0);
		wr(OFS_PTR, 32'h24);
		wr(OFS_DATA, 32'hf0);
		rd_chk("ptr", OFS_PTR, 8'h04);
		rd_chk("sub", OFS_SUB, 8'h01);
		repeat (200) @(posedge pclk);
		chk("seg", 40'hf83, 40'({segment_outputs[39:36], segment_outputs[7:0]}));
		wr(OFS_SUB, 32'h0);
		wr(OFS_CTRL, 32'h45);
		wr(OFS_PTR, 32'h0);
		wr(OFS_DATA, 32'h0f);
		repeat (200) @(posedge pclk);
		chk("seg", 40'h83, 40'(segment_outputs[7:0]));
		wr(OFS_CTRL, 32'hc5);
		repeat (200) @(posedge pclk);
		chk("seg", 40'hf0, 40'(segment_outputs[7:0]));
		wr(OFS_CTRL, 32'h0d);
		wait_seg(8'h00, c);
		wait_seg(8'h83, c);
		chk("blink", 40'h1, 40'(c >= 1520 && c <= 1552));
		wr(OFS_CTRL, 32'h2d);
		wait_seg(8'hf0, c);
		chk("alt", 40'h1, 40'(c < 4000));
		wait_seg(8'h83, c);
		chk("alt", 40'h1, 40'(c < 4000));
		for (int b = 2; b < 4; b++) begin
			wr(OFS_CTRL, 32'h05);
			wr(OFS_CTRL, {27'h0, 2'(b), 3'h5});
			d = (b == 2) ? BLINK_DIV_MID * 2 : BLINK_DIV_SLOW * 2;
			wait_seg(8'h00, c);
			wait_seg(8'h83, c);
			chk("blink", 40'(d), 40'(c));
		end
		wr(OFS_CTRL, 32'h01);
		repeat (4) @(posedge pclk);
		chk("dark", 40'h0, {segment_outputs[35:0], backplane_outputs});
		for (int i = 0; i < 4; i++) begin
			wr(OFS_CTRL, {28'h0, 2'h1, md[i]});
			row_mask(m);
			chk("rows", 40'(rm[i]), 40'(m));
			cascade_align <= 1'b1;
			repeat (300) @(posedge pclk);
			rd(OFS_STAT, r);
			chk("align", 40'(lr[i]), 40'(r[1:0]));
			chk("bp", 40'(mirror(md[i], 4'h1 << lr[i])), 40'(backplane_outputs));
			cascade_align <= 1'b0;
			wr(OFS_PTR, 32'h0);
			wr(OFS_DATA, 32'h0);
			rd_chk("ptr", OFS_PTR, stp[i]);
		end
		wr(OFS_CTRL, 32'h04);
		osc_select_pin <= 1'b1;
		repeat (20) @(posedge pclk);
		chk("oe", 40'h0, 40'(clk_pin_oe));
		chk("clkout", 40'h0, 40'(clk_pin_out));
		row_mask(m);
		chk("rows", 40'hf, 40'(m));
		osc_select_pin <= 1'b0;
		repeat (20) @(posedge pclk);
		chk("oe", 40'h1, 40'(clk_pin_oe));
		c = 0;
		repeat (8) begin
			@(posedge pclk);
			if (clk_pin_out === 1'b1)
				c++;
		end
		chk("clkout", 40'h4, 40'(c));
		end_of_test();
	end
endmodule : test_lrm_core
